// *** src/tcc_defs.svh ***
// Constants for the timing channel capture block
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH
`define TCC_CLK_NS        100
`define TCC_TICK_NS       100000
`define TCC_TICK_CYC      (`TCC_TICK_NS / `TCC_CLK_NS)
`define TCC_DAY_TK        32'h337F_9800
`define TCC_DLY_START_TK  32'h0000_2710
`define TCC_DLY_STOP_TK   32'h0000_0BB8
`define TCC_CORR_TK       32'h0000_03E8
`define TCC_HOLD_DEF_TK   32'h0001_86A0
`define TCC_NCH           9
`define TCC_NEDGE         6
`define TCC_NMOM          4
`define TCC_FIN_CH        1
`define TCC_A_CTRL        8'h00
`define TCC_A_CHEN        8'h04
`define TCC_A_LSTATE      8'h08
`define TCC_A_EDGE        8'h0C
`define TCC_A_CORR        8'h10
`define TCC_A_MIN         8'h14
`define TCC_A_MAX         8'h18
`define TCC_A_STN         8'h1C
`define TCC_A_BLK         8'h20
`define TCC_A_TOD         8'h24
`define TCC_A_CAPT        8'h28
`define TCC_A_CAPN        8'h2C
`define TCC_A_CAPI        8'h30
`define TCC_A_STAT        8'h34
`define TCC_A_DLY         8'h40
`define TCC_A_HFALL       8'h80
`define TCC_A_HRISE       8'hC0
`define TCC_C_PREC        2:0
`define TCC_C_RND         4:3
`define TCC_C_SEC         5
`define TCC_C_STADV       7:6
`define TCC_C_FNADV       9:8
`define TCC_C_LATCH       10
`define TCC_C_FIX         11
`define TCC_C_EALL        12
`define TCC_C_EDGE        14:13
`define TCC_C_RADIO       15
`endif

// *** src/tcc_pkg.sv ***
// Types for the timing channel capture block
package tcc_pkg;
   typedef enum logic [2:0] {TCC_P_1S, TCC_P_10, TCC_P_100, TCC_P_1000, TCC_P_10000} tcc_prec_type;
   typedef enum logic [1:0] {TCC_R_CUT, TCC_R_UP, TCC_R_MATH} tcc_round_type;
   typedef enum logic [1:0] {TCC_E_FALL, TCC_E_RISE, TCC_E_BOTH} tcc_edge_type;
   typedef enum logic [1:0] {TCC_S_MAN, TCC_S_UP, TCC_S_DOWN} tcc_stadv_type;
   typedef enum logic [1:0] {TCC_F_MAN, TCC_F_SINGLE, TCC_F_SEVERAL} tcc_fnadv_type;
   typedef enum logic [1:0] {TCC_L_ACTIVE, TCC_L_BLOCKED, TCC_L_INVALID} tcc_lstate_type;
endpackage : tcc_pkg

// *** src/tcc_top.sv ***
// Timing channel capture, qualification and net time unit
//
// Design decisions made here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "tcc_defs.svh"
module tcc_top
   import tcc_pkg::*;
(
   input  wire logic        clk,              // 10 MHz system clock
   input  wire logic        reset,            // Synchronous reset, active high
   input  wire logic        wb_cyc_i,         // Wishbone cycle
   input  wire logic        wb_stb_i,         // Wishbone strobe
   input  wire logic        wb_we_i,          // Wishbone write enable
   input  wire logic [7:0]  wb_adr_i,         // Wishbone byte address
   input  wire logic [3:0]  wb_sel_i,         // Wishbone byte selects
   input  wire logic [31:0] wb_dat_i,         // Wishbone write data
   output logic      [31:0] wb_dat_o,         // Wishbone read data
   output logic             wb_ack_o,         // Wishbone acknowledge
   input  wire logic [8:0]  contact_n,        // Contact inputs, low when closed
   input  wire logic [8:0]  radio_pulse,      // Remote impulse per channel
   input  wire logic        radio_internal,   // Remote impulse came by internal radio
   input  wire logic        key_shift,        // Shift key held
   input  wire logic [3:0]  key_fn,           // Function keys of channels 0 to 3
   output logic      [5:0]  radio_edge_out,   // Radio impulses replayed as edges
   output logic      [8:0]  link_enable,      // Enable pattern for linked unit
   output logic      [8:0]  link_enable_upd,  // Pulse: forward this channel enable
   output logic      [8:0]  pulse_hold,       // Pulse hold indication per channel
   output logic             cap_valid,        // Pulse: new capture
   output logic      [3:0]  cap_chan,         // Captured channel
   output logic      [31:0] cap_time,         // Captured time of day, ticks
   output logic             cap_invalid,      // Capture flagged invalid
   output logic             net_valid,        // Pulse: net time ready
   output logic      [31:0] net_time,         // Rounded net time, ticks
   output logic      [31:0] net_fmt,          // Formatted runtime
   output logic      [15:0] start_number,     // Current start number
   output logic      [15:0] finish_number     // Current finish number
);
   logic [31:0] ctrl_q, chen_q, lstate_q, edge_q, corr_q, min_q, max_q, blk_q;
   logic [15:0] stn_q, fin_q, last_start_q;
   logic [31:0] dly_q [`TCC_NCH];
   logic [31:0] hfall_q [`TCC_NCH];
   logic [31:0] hrise_q [`TCC_NCH];
   logic [9:0]  tick_cnt_q;
   logic        tick;
   logic [31:0] tod_q;
   logic [6:0]  sub100_q;
   logic        ack_q;
   logic [31:0] rdat_q;
   logic        wr;
   logic [7:0]  adr;
   logic [8:0]  pend_q, pend_inv_q, take;
   logic [31:0] pend_time_q [`TCC_NCH];
   logic [31:0] start_time_q;
   logic        on_course_q;
   logic        cap_valid_q, cap_inv_q, net_valid_q;
   logic [3:0]  cap_chan_q;
   logic [31:0] cap_time_q, cap_net_q, net_q, fmt_q;
   logic [3:0]  sel;
   logic        sel_any;
   logic [31:0] raw_net, max_el;
   logic        min_fail, max_hit, start_acc;

   assign wr  = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_q;
   assign adr = {wb_adr_i[7:2], 2'b00};

   // Tick of 1/10000 s and time of day
   always_ff @(posedge clk) begin
      if (reset || tick) tick_cnt_q <= '0;
      else tick_cnt_q <= tick_cnt_q + 10'd1;
   end
   assign tick = (tick_cnt_q == 10'(`TCC_TICK_CYC - 1));

   always_ff @(posedge clk) begin
      if (reset) begin
         tod_q    <= '0;
         sub100_q <= '0;
      end else if (wr && adr == `TCC_A_TOD) begin
         tod_q    <= wb_dat_i;
         sub100_q <= 7'(wb_dat_i % 32'd100);
      end else if (tick) begin
         tod_q    <= (tod_q == `TCC_DAY_TK - 32'd1) ? '0 : tod_q + 32'd1;
         sub100_q <= (sub100_q == 7'd99) ? '0 : sub100_q + 7'd1;
      end
   end

   // Wishbone slave, one wait state
   always_ff @(posedge clk) begin
      if (reset) ack_q <= 1'b0;
      else ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
   end
   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;

   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl_q   <= '0;
         chen_q   <= 32'h0000_01FF;
         lstate_q <= '0;
         edge_q   <= '0;
         corr_q   <= '0;
         min_q    <= '0;
         max_q    <= '0;
         blk_q    <= '0;
      end else if (wr) begin
         unique case (adr)
            `TCC_A_CTRL: begin
               ctrl_q <= wb_dat_i;
               if (ctrl_q[`TCC_C_FIX] && wb_dat_i[`TCC_C_FIX])
                  ctrl_q[`TCC_C_LATCH] <= ctrl_q[`TCC_C_LATCH];
            end
            `TCC_A_CHEN:   chen_q   <= wb_dat_i;
            `TCC_A_LSTATE: lstate_q <= wb_dat_i;
            `TCC_A_EDGE:   edge_q   <= wb_dat_i;
            `TCC_A_CORR:   corr_q   <= wb_dat_i;
            `TCC_A_MIN:    min_q    <= wb_dat_i;
            `TCC_A_MAX:    max_q    <= wb_dat_i;
            `TCC_A_BLK:    blk_q    <= wb_dat_i;
            default: ;
         endcase
      end
   end

   // Forward the enable pattern, with update pulses for the channels set in bits 24:16 of a CHEN write
   always_ff @(posedge clk) begin
      if (reset) begin
         link_enable     <= 9'h1FF;
         link_enable_upd <= '0;
      end else begin
         link_enable     <= chen_q[8:0];
         link_enable_upd <= (wr && adr == `TCC_A_CHEN) ? wb_dat_i[24:16] : 9'h000;
      end
   end

   // Per-entry timing registers
   always_ff @(posedge clk) begin
      if (reset) begin
         for (int i = 0; i < `TCC_NCH; i++) begin
            dly_q[i]   <= (i == 0) ? `TCC_DLY_START_TK : `TCC_DLY_STOP_TK;
            hfall_q[i] <= `TCC_HOLD_DEF_TK;
            hrise_q[i] <= `TCC_HOLD_DEF_TK;
         end
      end else if (wr) begin
         for (int i = 0; i < `TCC_NCH; i++) begin
            if (adr == `TCC_A_DLY + 8'(4 * i))   dly_q[i]   <= wb_dat_i;
            if (adr == `TCC_A_HFALL + 8'(4 * i)) hfall_q[i] <= wb_dat_i;
            if (adr == `TCC_A_HRISE + 8'(4 * i)) hrise_q[i] <= wb_dat_i;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) rdat_q <= '0;
      else begin
         rdat_q <= '0;
         unique case (adr)
            `TCC_A_CTRL:   rdat_q <= ctrl_q;
            `TCC_A_CHEN:   rdat_q <= chen_q;
            `TCC_A_LSTATE: rdat_q <= lstate_q;
            `TCC_A_EDGE:   rdat_q <= edge_q;
            `TCC_A_CORR:   rdat_q <= corr_q;
            `TCC_A_MIN:    rdat_q <= min_q;
            `TCC_A_MAX:    rdat_q <= max_q;
            `TCC_A_STN:    rdat_q <= {fin_q, stn_q};
            `TCC_A_BLK:    rdat_q <= blk_q;
            `TCC_A_TOD:    rdat_q <= tod_q;
            `TCC_A_CAPT:   rdat_q <= cap_time_q;
            `TCC_A_CAPN:   rdat_q <= net_q;
            `TCC_A_CAPI:   rdat_q <= {cap_inv_q, 27'd0, cap_chan_q};
            `TCC_A_STAT:   rdat_q <= {22'd0, on_course_q, pulse_hold};
            default: begin
               for (int i = 0; i < `TCC_NCH; i++) begin
                  if (adr == `TCC_A_DLY + 8'(4 * i))   rdat_q <= dly_q[i];
                  if (adr == `TCC_A_HFALL + 8'(4 * i)) rdat_q <= hfall_q[i];
                  if (adr == `TCC_A_HRISE + 8'(4 * i)) rdat_q <= hrise_q[i];
               end
            end
         endcase
      end
   end

   // Per-channel qualification
   for (genvar g = 0; g < `TCC_NCH; g++) begin : g_ch
      logic        s1_q, s2_q, s3_q;
      logic        rise, fall, hit, phys, radio_pkt, blocked, inv;
      logic [31:0] dly_cnt_q, blk_cnt_q, hold_cnt_q, stamp, ptime;
      tcc_edge_type esel;
      tcc_lstate_type ls;

      always_ff @(posedge clk) begin
         if (reset) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
         end else begin
            s1_q <= contact_n[g];
            s2_q <= s1_q;
            s3_q <= s2_q;
         end
      end
      assign fall = s3_q & ~s2_q;
      assign rise = ~s3_q & s2_q;

      if (g < `TCC_NEDGE) begin : g_sel
         assign esel = tcc_edge_type'(ctrl_q[`TCC_C_EALL] ? ctrl_q[`TCC_C_EDGE]
                                                          : edge_q[2*g +: 2]);
         assign radio_edge_out[g] = radio_pulse[g] & ctrl_q[`TCC_C_RADIO]
                                    & corr_q[9+g];
      end else begin : g_fix
         assign esel = TCC_E_FALL;
      end

      assign ls = tcc_lstate_type'(lstate_q[2*g +: 2]);
      assign hit = (esel == TCC_E_FALL) ? fall :
                   (esel == TCC_E_RISE) ? rise : (fall | rise);
      if (g < `TCC_NMOM) begin : g_mom
         assign blocked = ctrl_q[`TCC_C_LATCH] ? (ls == TCC_L_BLOCKED)
                                               : (key_shift & key_fn[g]);
      end else begin : g_nomom
         assign blocked = ctrl_q[`TCC_C_LATCH] & (ls == TCC_L_BLOCKED);
      end
      assign radio_pkt = radio_pulse[g] & ~(g < `TCC_NEDGE && ctrl_q[`TCC_C_RADIO]
                                            && corr_q[9+g]);
      assign phys = (hit | radio_pulse[g]) & chen_q[g] & ~blocked
                    & (dly_cnt_q == '0);
      assign stamp = (g >= `TCC_NEDGE) ? tod_q - 32'(sub100_q) : tod_q;
      assign ptime = (radio_pkt && (radio_internal || corr_q[g]))
                     ? ((stamp < `TCC_CORR_TK) ? stamp + `TCC_DAY_TK : stamp) - `TCC_CORR_TK
                     : stamp;
      assign inv = (blk_cnt_q != '0)
                   | (ctrl_q[`TCC_C_LATCH] & (ls == TCC_L_INVALID));

      always_ff @(posedge clk) begin
         if (reset) begin
            dly_cnt_q <= '0;
            blk_cnt_q <= '0;
         end else begin
            if (phys) dly_cnt_q <= dly_q[g];
            else if (tick && dly_cnt_q != '0) dly_cnt_q <= dly_cnt_q - 32'd1;
            if (phys && !inv) blk_cnt_q <= blk_q;
            else if (tick && blk_cnt_q != '0) blk_cnt_q <= blk_cnt_q - 32'd1;
         end
      end

      always_ff @(posedge clk) begin
         if (reset) begin
            pend_q[g]      <= 1'b0;
            pend_inv_q[g]  <= 1'b0;
            pend_time_q[g] <= '0;
         end else if (phys) begin
            pend_q[g]      <= 1'b1;                     // Set wins over take
            pend_inv_q[g]  <= inv;
            pend_time_q[g] <= ptime;
         end else if (take[g]) begin
            pend_q[g] <= 1'b0;
         end
      end

      always_ff @(posedge clk) begin
         if (reset) hold_cnt_q <= '0;
         else if (fall || rise) hold_cnt_q <= '0;
         else if (tick && hold_cnt_q != 32'hFFFF_FFFF) hold_cnt_q <= hold_cnt_q + 32'd1;
      end
      always_ff @(posedge clk) begin
         if (reset) pulse_hold[g] <= 1'b0;
         else pulse_hold[g] <= s3_q ? (hold_cnt_q >= hfall_q[g])
                                    : (hold_cnt_q >= hrise_q[g]);
      end
   end

   // Lowest pending channel is taken first
   always_comb begin
      sel     = '0;
      sel_any = 1'b0;
      take    = '0;
      for (int i = `TCC_NCH - 1; i >= 0; i--) begin
         if (pend_q[i]) begin
            sel     = 4'(i);
            sel_any = 1'b1;
         end
      end
      if (sel_any) take[sel] = 1'b1;
   end

   assign raw_net   = pend_time_q[sel] - start_time_q;
   assign min_fail  = (min_q != '0) && (sel != 4'd0) && (raw_net < min_q);
   assign start_acc = sel_any && (sel == 4'd0) && !pend_inv_q[0];
   assign max_el    = tod_q - start_time_q;
   assign max_hit   = (max_q != '0) && on_course_q && (max_el >= max_q);

   always_ff @(posedge clk) begin
      if (reset) begin
         cap_valid_q <= 1'b0;
         cap_chan_q  <= '0;
         cap_time_q  <= '0;
         cap_inv_q   <= 1'b0;
         cap_net_q   <= '0;
      end else begin
         cap_valid_q <= sel_any;
         if (sel_any) begin
            cap_chan_q <= sel;
            cap_time_q <= pend_time_q[sel];
            cap_inv_q  <= pend_inv_q[sel] | min_fail;
            cap_net_q  <= (sel == 4'd0) ? '0 : raw_net;
         end
      end
   end

   // Start and finish numbers, course tracking
   always_ff @(posedge clk) begin
      if (reset) begin
         stn_q        <= 16'h0001;
         fin_q        <= 16'h0001;
         last_start_q <= 16'h0001;
         start_time_q <= '0;
         on_course_q  <= 1'b0;
      end else begin
         if (wr && adr == `TCC_A_STN) begin
            stn_q <= wb_dat_i[15:0];
            fin_q <= wb_dat_i[31:16];
         end
         if (start_acc) begin
            start_time_q <= pend_time_q[0];
            on_course_q  <= 1'b1;
            last_start_q <= stn_q;
            unique case (tcc_stadv_type'(ctrl_q[`TCC_C_STADV]))
               TCC_S_UP:   stn_q <= stn_q + 16'd1;
               TCC_S_DOWN: stn_q <= stn_q - 16'd1;
               default:    ;
            endcase
         end else if (max_hit || (sel_any && sel == 4'(`TCC_FIN_CH)
                                  && !pend_inv_q[sel] && !min_fail)) begin
            on_course_q <= 1'b0;
            unique case (tcc_fnadv_type'(ctrl_q[`TCC_C_FNADV]))
               TCC_F_SINGLE:  fin_q <= max_hit ? stn_q : last_start_q;
               TCC_F_SEVERAL: fin_q <= fin_q + 16'd1;
               default:       ;
            endcase
         end
      end
   end

   // Net time rounding and formatting
   function automatic logic [31:0] tcc_round(input logic [31:0] t, input logic [2:0] p,
                                             input logic [1:0] m);
      logic [31:0] d, r;
      d = 32'd1;
      unique case (tcc_prec_type'(p))
         TCC_P_1S:   d = 32'd10000;
         TCC_P_10:   d = 32'd1000;
         TCC_P_100:  d = 32'd100;
         TCC_P_1000: d = 32'd10;
         default:    d = 32'd1;
      endcase
      r = t % d;
      unique case (tcc_round_type'(m))
         TCC_R_UP:   tcc_round = (r != '0) ? t - r + d : t;
         TCC_R_MATH: tcc_round = (r >= (d >> 1) && d != 32'd1) ? t - r + d : t - r;
         default:    tcc_round = t - r;
      endcase
   endfunction : tcc_round

   function automatic logic [31:0] tcc_format(input logic [31:0] t, input logic sec);
      logic [31:0] h, s;
      h = t / 32'd100;
      s = h / 32'd100;
      if (sec) tcc_format = {s[23:0], 8'(h % 32'd100)};
      else tcc_format = {8'(s / 32'd3600), 8'((s / 32'd60) % 32'd60),
                         8'(s % 32'd60), 8'(h % 32'd100)};
   endfunction : tcc_format

   always_ff @(posedge clk) begin
      if (reset) begin
         net_valid_q <= 1'b0;
         net_q       <= '0;
         fmt_q       <= '0;
      end else begin
         net_valid_q <= cap_valid_q;
         if (cap_valid_q) begin
            net_q <= tcc_round(cap_net_q, ctrl_q[`TCC_C_PREC], ctrl_q[`TCC_C_RND]);
            fmt_q <= tcc_format(tcc_round(cap_net_q, ctrl_q[`TCC_C_PREC],
                                          ctrl_q[`TCC_C_RND]), ctrl_q[`TCC_C_SEC]);
         end
      end
   end

   assign cap_valid     = cap_valid_q;
   assign cap_chan      = cap_chan_q;
   assign cap_time      = cap_time_q;
   assign cap_invalid   = cap_inv_q;
   assign net_valid     = net_valid_q;
   assign net_time      = net_q;
   assign net_fmt       = fmt_q;
   assign start_number  = stn_q;
   assign finish_number = fin_q;
endmodule : tcc_top

// *** testbench/tcc_monitor.sv ***
// Port checks for the capture unit
`timescale 1ns/10ps
`include "tcc_defs.svh"
module tcc_monitor (
   input wire logic        clk,             // Clock
   input wire logic        reset,           // Reset
   input wire logic        wb_cyc_i,        // Bus cycle
   input wire logic        wb_stb_i,        // Bus strobe
   input wire logic        wb_ack_o,        // Bus ack
   input wire logic [8:0]  radio_pulse,     // Remote impulses
   input wire logic [5:0]  radio_edge_out,  // Replayed edges
   input wire logic [8:0]  link_enable,     // Enable pattern
   input wire logic [8:0]  link_enable_upd, // Forward pulses
   input wire logic        cap_valid,       // Capture pulse
   input wire logic [3:0]  cap_chan,        // Channel
   input wire logic [31:0] cap_time,        // Time of day
   input wire logic        net_valid        // Net pulse
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   AST_ACK_NEXT:
   assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   AST_ACK_PULSE:
   assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   AST_NET_FOLLOW:
   assert property (cap_valid |=> net_valid) else $error("net missing");
   AST_NET_CAUSE:
   assert property (net_valid |-> $past(cap_valid)) else $error("net without capture");
   AST_RADIO_EDGE:
   assert property ((radio_edge_out & ~radio_pulse[5:0]) == 6'h00)
      else $error("edge without pulse");
   AST_ENABLED:
   assert property (cap_valid |-> link_enable[cap_chan]) else $error("disabled capture");
   AST_FWD_PULSE:
   assert property (|link_enable_upd |=> link_enable_upd == 9'h000)
      else $error("forward pulse long");
   AST_LOW_RES:
   assert property (cap_valid && cap_chan > 4'h5 |-> cap_time % 32'h0000_0064 == 32'h0)
      else $error("stamp not hundredths");
   AST_DAY_RANGE:
   assert property (cap_valid |-> cap_time < `TCC_DAY_TK) else $error("stamp past day");
endmodule : tcc_monitor
bind tcc_top tcc_monitor mon (.clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .radio_pulse,
   .radio_edge_out, .link_enable, .link_enable_upd, .cap_valid, .cap_chan, .cap_time,
   .net_valid);

// *** testbench/tcc_contact_model.sv ***
// Contact switch bank at the capture inputs
`timescale 1ns/10ps
module tcc_contact_model (
   input  wire logic       clk,       // Clock
   output logic      [8:0] contact_n  // Low when closed
);
   initial contact_n = 9'h1FF;
   task automatic set_ch(input int ch, input logic closed);
      @(posedge clk);
      contact_n[ch] <= ~closed;
      repeat (4) @(posedge clk);
   endtask : set_ch
endmodule : tcc_contact_model

// *** testbench/tcc_top_tb.sv ***
// Self-checking bench of the capture unit
`timescale 1ns/10ps
`include "tcc_defs.svh"
module tcc_top_tb
   import tcc_pkg::*;
;
   typedef struct {logic we; logic [7:0] a; logic [31:0] d; logic [31:0] e;} tcc_row_type;
   localparam int DLY_WAIT = 3000; // Beyond a 2 tick delay
   logic clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, radio_internal, key_shift;
   logic cap_valid, cap_invalid, net_valid;
   logic [7:0]  wb_adr_i;
   logic [3:0]  wb_sel_i, key_fn, cap_chan;
   logic [31:0] wb_dat_i, wb_dat_o, cap_time, net_time, net_fmt, r;
   logic [8:0]  contact_n, radio_pulse, link_enable, link_enable_upd, pulse_hold;
   logic [5:0]  radio_edge_out;
   logic [15:0] start_number, finish_number;
   int n_errors = 0;
   int total_checks = 0;
   tcc_row_type rows [8] = '{
      '{0, `TCC_A_CHEN, '0, 32'h0000_01FF},
      '{0, `TCC_A_DLY, '0, `TCC_DLY_START_TK},
      '{0, 8'h60, '0, `TCC_DLY_STOP_TK},
      '{0, `TCC_A_HFALL, '0, `TCC_HOLD_DEF_TK},
      '{0, 8'hE0, '0, `TCC_HOLD_DEF_TK},
      '{1, 8'h44, 32'h0000_0002, '0},
      '{0, 8'h44, '0, 32'h0000_0002},
      '{0, 8'h3C, '0, '0}};
   tcc_top dut (.clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .contact_n, .radio_pulse, .radio_internal,
      .key_shift, .key_fn, .radio_edge_out, .link_enable, .link_enable_upd, .pulse_hold,
      .cap_valid, .cap_chan, .cap_time, .cap_invalid, .net_valid, .net_time, .net_fmt,
      .start_number, .finish_number);
   tcc_contact_model m (.clk, .contact_n);
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task bus(input logic we, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
      do begin
         @(posedge clk);
      end while (wb_ack_o !== 1'b1);
      r = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
   endtask : bus
   task pulse(input int ch);
      @(posedge clk);
      radio_pulse[ch] <= 1'b1;
      @(posedge clk);
      radio_pulse[ch] <= 1'b0;
   endtask : pulse
   task capw(input logic [3:0] ch, input logic inv, input logic want);
      int n;
      n = 0;
      while (cap_valid !== 1'b1 && n < 30) begin
         @(posedge clk);
         n++;
      end
      chk("cap_valid", cap_valid, want);
      if (want) begin
         chk("cap_chan", cap_chan, ch);
         chk("cap_invalid", cap_invalid, inv);
         @(posedge clk);
      end
   endtask : capw
   task wrap_up;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : wrap_up
   initial begin
      {reset, wb_cyc_i, wb_stb_i, wb_we_i, radio_internal, key_shift} = 6'b100000;
      {wb_adr_i, wb_sel_i, key_fn, wb_dat_i, radio_pulse} = '0;
      wb_sel_i = 4'hF;
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      foreach (rows[i]) begin
         bus(rows[i].we, rows[i].a, rows[i].d);
         if (!rows[i].we) chk("register", r, rows[i].e);
      end
      m.set_ch(1, 1'b1);
      capw(4'h1, 1'b0, 1'b1);
      m.set_ch(1, 1'b0);
      m.set_ch(1, 1'b1);
      capw(4'h1, 1'b0, 1'b0);
      bus(1'b1, `TCC_A_BLK, 32'h0000_0014);
      repeat (DLY_WAIT) @(posedge clk);
      m.set_ch(1, 1'b0);
      capw(4'h1, 1'b0, 1'b0);
      m.set_ch(1, 1'b1);
      capw(4'h1, 1'b0, 1'b1);
      repeat (DLY_WAIT) @(posedge clk);
      m.set_ch(1, 1'b0);
      m.set_ch(1, 1'b1);
      capw(4'h1, 1'b1, 1'b1);
      bus(1'b1, `TCC_A_CHEN, 32'h0004_01FB);
      chk("link_enable_upd", link_enable_upd, 32'h0000_0004);
      pulse(2);
      capw(4'h2, 1'b0, 1'b0);
      chk("link_enable", link_enable, 32'h0000_01FB);
      bus(1'b1, `TCC_A_CHEN, 32'h0000_01FF);
      pulse(2);
      capw(4'h2, 1'b0, 1'b1);
      {key_shift, key_fn} <= 5'h18;
      pulse(3);
      capw(4'h3, 1'b0, 1'b0);
      {key_shift, key_fn} <= 5'h00;
      pulse(3);
      capw(4'h3, 1'b0, 1'b1);
      bus(1'b1, `TCC_A_CTRL, 32'h0000_0400);
      bus(1'b1, `TCC_A_LSTATE, 32'h0000_0200);
      pulse(4);
      capw(4'h4, 1'b1, 1'b1);
      chk("net_time", net_time % 32'h0000_2710, '0);
      bus(1'b1, `TCC_A_MIN, 32'h0100_0000);
      pulse(5);
      capw(4'h5, 1'b1, 1'b1);
      bus(1'b1, `TCC_A_MIN, '0);
      pulse(6);
      capw(4'h6, 1'b0, 1'b1);
      bus(1'b1, 8'h9C, 32'h0000_0001);
      repeat (2) @(posedge clk);
      chk("pulse_hold", pulse_hold, 32'h0000_0080);
      bus(1'b1, `TCC_A_MAX, 32'h0000_0001);
      bus(1'b1, `TCC_A_CORR, 32'h0000_0200);
      bus(1'b1, `TCC_A_CTRL, 32'h0000_8240);
      radio_pulse[0] <= 1'b1;
      @(posedge clk);
      chk("radio_edge_out", radio_edge_out, 32'h0000_0001);
      radio_pulse[0] <= 1'b0;
      capw(4'h0, 1'b0, 1'b1);
      chk("start_number", start_number, 32'h0000_0002);
      repeat (2000) @(posedge clk);
      chk("finish_number", finish_number, 32'h0000_0002);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      chk("start_number", start_number, 32'h0000_0001);
      chk("finish_number", finish_number, 32'h0000_0001);
      chk("link_enable", link_enable, 32'h0000_01FF);
      wrap_up;
   end
   initial begin
      repeat (30000) @(posedge clk);
      n_errors++;
      wrap_up;
   end
endmodule : tcc_top_tb
